/* logic/vvl_regs.svh */
`ifndef VVL_REGS_SVH
`define VVL_REGS_SVH
// ****************************************
// Command codes
// ****************************************
`define VVL_CMD_CLEAR_FAULTS   8'h03
`define VVL_CMD_FMT_EXP        8'h20
`define VVL_CMD_SETPOINT       8'h21
`define VVL_CMD_CEILING        8'h24
`define VVL_CMD_MARGIN_UP      8'h25
`define VVL_CMD_MARGIN_LO      8'h26
`define VVL_CMD_DIV_RATIO      8'h29
`define VVL_CMD_FLOOR          8'h2B
`define VVL_CMD_INPUT_TURN_ON_THRESHOLD         8'h35
`define VVL_CMD_INPUT_TURN_OFF_THRESHOLD        8'h36
// ****************************************
// Field positions
// ****************************************
`define VVL_FMT_SEL_MSB        7
`define VVL_FMT_SEL_LSB        5
`define VVL_FMT_EXP_MSB        4
`define VVL_FMT_EXP_LSB        0
`define VVL_VAL_MSB            11
// ****************************************
// Reset values and limits
// ****************************************
`define VVL_FMT_DIRECT         3'h2
`define VVL_FMT_EXP_RST        5'h00
`define VVL_SETPOINT_RST       12'h384
`define VVL_CEILING_RST        12'hBB8
`define VVL_CEILING_TOP        12'hBB8
`define VVL_FLOOR_RST          12'h0FA
`define VVL_FLOOR_BOTTOM       12'h0FA
`define VVL_MARGIN_UP_RST      12'h000
`define VVL_MARGIN_LO_RST      12'h000
`define VVL_DIV_RATIO_RST      12'h14F
`define VVL_INPUT_TURN_ON_THRESHOLD_RST         12'h010
`define VVL_INPUT_TURN_ON_THRESHOLD_MIN         12'h010
`define VVL_INPUT_TURN_ON_THRESHOLD_MAX         12'h03C
`define VVL_INPUT_TURN_OFF_THRESHOLD_RST        12'h00B
`define VVL_INPUT_TURN_OFF_THRESHOLD_MIN        12'h00F
`define VVL_INPUT_TURN_OFF_THRESHOLD_MAX        12'h03B
`endif

/* logic/vvl_pkg.sv */
package vvl_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       send;
        logic [7:0] cmd;
        logic [15:0] data;
    } vvl_req_t;

    typedef enum logic [1:0] {
        VVL_OFF   = 2'b00,
        VVL_ON    = 2'b01
    } vvl_conv_t;

    typedef struct packed {
        logic [7:0]  fmt;
        logic [11:0] setpoint;
        logic [11:0] ceiling;
        logic [11:0] margin_up;
        logic [11:0] margin_lo;
        logic [11:0] div_ratio;
        logic [11:0] floor_v;
        logic [11:0] input_turn_on_threshold;
        logic [11:0] input_turn_off_threshold;
        logic        other_fault_summary_bit;
        logic        vout_word_bit;
        logic        vout_minmax_warn;
        logic        notify;
        logic [15:0] rdata;
        logic        rvalid;
        logic [23:0] fb_ref;
        vvl_conv_t   conv;
    } vvl_state_t;
endpackage

/* logic/vvl_limits.sv */
`timescale 1ns/1ps
`include "vvl_regs.svh"
// Behaviour
// - Format byte: 3-bit direct selector, 5-bit exponent
// - Reference equals setpoint times scale factor
// - Setpoint 12 bits, 2 mV/LSB, upper read-only
// - Setpoint resets to 1.8 V
// - Request above ceiling clamps to ceiling
// - Clamp sets summary, word, warning; notify host
// - Ceiling 2 mV/LSB, max 6 V, reset 6 V
// - Request below floor clamps to floor
// - Floor 2 mV/LSB, minimum 0.5 V, reset 0.5 V
// - Margins 12-bit 2 mV/LSB, upper read-only
// - Scale factor 0.001/LSB, resets to 0.335
// - Turn on only at threshold, conditions met
// - On threshold 250 mV, 4-15 V, reset 4 V
// - Turn off when input falls to threshold
// - Off threshold 250 mV, 3.75-14.75 V, reset 2.75 V
// - Clear-faults send-byte resets stored flags
module vvl_limits
    import vvl_pkg::*;
(
    input  wire logic        clk,           // 100 MHz clock
    input  wire logic        reset,         // Synchronous, active high
    input  wire vvl_req_t    req,           // Command from serial engine
    input  wire logic [11:0] vin_code,      // Input voltage, 250 mV/LSB
    input  wire logic        power_up_ok,   // Other power-up conditions met
    output logic      [15:0] rdata,         // Read data
    output logic             rvalid,        // Read data valid pulse
    output logic      [23:0] fb_ref,        // Setpoint times scale factor
    output logic             conv_enable,   // Converter run request
    output logic             other_fault_summary_bit, // Summary flag
    output logic             vout_word_bit, // Output-voltage word flag
    output logic             vout_minmax_warn, // Clamp warning flag
    output logic             notify         // Alert to host, level
);

    vvl_state_t s_r;
    vvl_state_t s_nxt;
    logic [11:0] wv;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt        = s_r;
        wv           = req.data[`VVL_VAL_MSB:0];
        s_nxt.rvalid = 1'b0;
        s_nxt.fb_ref = s_r.setpoint * s_r.div_ratio;

        if (req.send && req.cmd == `VVL_CMD_CLEAR_FAULTS) begin
            s_nxt.other_fault_summary_bit = 1'b0;
            s_nxt.vout_word_bit           = 1'b0;
            s_nxt.vout_minmax_warn        = 1'b0;
            s_nxt.notify                  = 1'b0;
        end

        if (req.wr) begin
            if (req.cmd == `VVL_CMD_FMT_EXP) begin
                // Only direct format exists; selector stays fixed
                s_nxt.fmt[`VVL_FMT_EXP_MSB:`VVL_FMT_EXP_LSB] =
                    req.data[`VVL_FMT_EXP_MSB:`VVL_FMT_EXP_LSB];
            end else if (req.cmd == `VVL_CMD_SETPOINT) begin
                if (wv > s_r.ceiling) begin
                    s_nxt.setpoint = s_r.ceiling;
                end else if (wv < s_r.floor_v) begin
                    s_nxt.setpoint = s_r.floor_v;
                end else begin
                    s_nxt.setpoint = wv;
                end
                if (wv > s_r.ceiling || wv < s_r.floor_v) begin
                    // Set wins over a clear in the same cycle
                    s_nxt.other_fault_summary_bit = 1'b1;
                    s_nxt.vout_word_bit           = 1'b1;
                    s_nxt.vout_minmax_warn        = 1'b1;
                    s_nxt.notify                  = 1'b1;
                end
            end else if (req.cmd == `VVL_CMD_CEILING) begin
                s_nxt.ceiling = (wv > `VVL_CEILING_TOP) ? `VVL_CEILING_TOP : wv;
            end else if (req.cmd == `VVL_CMD_MARGIN_UP) begin
                s_nxt.margin_up = wv;
            end else if (req.cmd == `VVL_CMD_MARGIN_LO) begin
                s_nxt.margin_lo = wv;
            end else if (req.cmd == `VVL_CMD_DIV_RATIO) begin
                s_nxt.div_ratio = wv;
            end else if (req.cmd == `VVL_CMD_FLOOR) begin
                s_nxt.floor_v = (wv < `VVL_FLOOR_BOTTOM) ? `VVL_FLOOR_BOTTOM : wv;
            end else if (req.cmd == `VVL_CMD_INPUT_TURN_ON_THRESHOLD) begin
                // Out-of-range codes saturate to the nearest legal step
                if (wv < `VVL_INPUT_TURN_ON_THRESHOLD_MIN) begin
                    s_nxt.input_turn_on_threshold = `VVL_INPUT_TURN_ON_THRESHOLD_MIN;
                end else if (wv > `VVL_INPUT_TURN_ON_THRESHOLD_MAX) begin
                    s_nxt.input_turn_on_threshold = `VVL_INPUT_TURN_ON_THRESHOLD_MAX;
                end else begin
                    s_nxt.input_turn_on_threshold = wv;
                end
            end else if (req.cmd == `VVL_CMD_INPUT_TURN_OFF_THRESHOLD) begin
                if (wv < `VVL_INPUT_TURN_OFF_THRESHOLD_MIN) begin
                    s_nxt.input_turn_off_threshold = `VVL_INPUT_TURN_OFF_THRESHOLD_MIN;
                end else if (wv > `VVL_INPUT_TURN_OFF_THRESHOLD_MAX) begin
                    s_nxt.input_turn_off_threshold = `VVL_INPUT_TURN_OFF_THRESHOLD_MAX;
                end else begin
                    s_nxt.input_turn_off_threshold = wv;
                end
            end
        end

        if (req.rd) begin
            s_nxt.rvalid = 1'b1;
            if (req.cmd == `VVL_CMD_FMT_EXP) begin
                s_nxt.rdata = {8'h00, s_r.fmt};
            end else if (req.cmd == `VVL_CMD_SETPOINT) begin
                s_nxt.rdata = {4'h0, s_r.setpoint};
            end else if (req.cmd == `VVL_CMD_CEILING) begin
                s_nxt.rdata = {4'h0, s_r.ceiling};
            end else if (req.cmd == `VVL_CMD_MARGIN_UP) begin
                s_nxt.rdata = {4'h0, s_r.margin_up};
            end else if (req.cmd == `VVL_CMD_MARGIN_LO) begin
                s_nxt.rdata = {4'h0, s_r.margin_lo};
            end else if (req.cmd == `VVL_CMD_DIV_RATIO) begin
                s_nxt.rdata = {4'h0, s_r.div_ratio};
            end else if (req.cmd == `VVL_CMD_FLOOR) begin
                s_nxt.rdata = {4'h0, s_r.floor_v};
            end else if (req.cmd == `VVL_CMD_INPUT_TURN_ON_THRESHOLD) begin
                s_nxt.rdata = {4'h0, s_r.input_turn_on_threshold};
            end else if (req.cmd == `VVL_CMD_INPUT_TURN_OFF_THRESHOLD) begin
                s_nxt.rdata = {4'h0, s_r.input_turn_off_threshold};
            end else begin
                s_nxt.rdata = 16'h0000;
            end
        end

        // Hysteresis depends on host keeping on above off
        case (s_r.conv)
            VVL_OFF: begin
                if (vin_code >= s_r.input_turn_on_threshold && power_up_ok) begin
                    s_nxt.conv = VVL_ON;
                end
            end
            VVL_ON: begin
                if (vin_code <= s_r.input_turn_off_threshold || !power_up_ok) begin
                    s_nxt.conv = VVL_OFF;
                end
            end
            default: s_nxt.conv = VVL_OFF;
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            s_r                         <= '0;
            s_r.fmt                     <= {`VVL_FMT_DIRECT, `VVL_FMT_EXP_RST};
            s_r.setpoint                <= `VVL_SETPOINT_RST;
            s_r.ceiling                 <= `VVL_CEILING_RST;
            s_r.margin_up               <= `VVL_MARGIN_UP_RST;
            s_r.margin_lo               <= `VVL_MARGIN_LO_RST;
            s_r.div_ratio               <= `VVL_DIV_RATIO_RST;
            s_r.floor_v                 <= `VVL_FLOOR_RST;
            s_r.input_turn_on_threshold                  <= `VVL_INPUT_TURN_ON_THRESHOLD_RST;
            s_r.input_turn_off_threshold                 <= `VVL_INPUT_TURN_OFF_THRESHOLD_RST;
            s_r.conv                    <= VVL_OFF;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata                   = s_r.rdata;
    assign rvalid                  = s_r.rvalid;
    assign fb_ref                  = s_r.fb_ref;
    // Run state is the only code with bit 0 set, so the pin is a plain flop bit
    assign conv_enable             = s_r.conv[0];
    assign other_fault_summary_bit = s_r.other_fault_summary_bit;
    assign vout_word_bit           = s_r.vout_word_bit;
    assign vout_minmax_warn        = s_r.vout_minmax_warn;
    assign notify                  = s_r.notify;

endmodule

/* sim/vvl_limits_monitor.sv */
`timescale 1ns/1ps
module vvl_limits_monitor
    import vvl_pkg::*;
(
    input wire logic        clk, // Clock
    input wire logic        reset, // Reset
    input wire vvl_req_t    req, // Command
    input wire logic [11:0] vin_code, // Input volts
    input wire logic        power_up_ok, // Permit
    input wire logic        rvalid, // Read pulse
    input wire logic        conv_enable, // Run
    input wire logic        other_fault_summary_bit, // Summary
    input wire logic        vout_word_bit, // Word flag
    input wire logic        vout_minmax_warn, // Warning
    input wire logic        notify // Alert
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire clr    = req.send && req.cmd == 8'h03;
    wire wsp    = req.wr && req.cmd == 8'h21;
    wire can_on = power_up_ok && vin_code >= 12'h010;
    // Reset off threshold, below the 12'h00F write minimum, so this drop holds whatever the host set
    wire drop   = !power_up_ok || vin_code <= 12'h00B;
    property p_rd; 1'b1 |=> rvalid == $past(req.rd); endproperty
    a_rd: assert property (p_rd) else $error("read pulse wrong");
    property p_hi; wsp && req.data[11:0] > 12'hBB8 |=> vout_minmax_warn; endproperty
    a_hi: assert property (p_hi) else $error("high clamp missed");
    property p_lo; wsp && req.data[11:0] < 12'h0FA |=> vout_minmax_warn; endproperty
    a_lo: assert property (p_lo) else $error("low clamp missed");
    property p_set; $rose(vout_minmax_warn) |-> vout_word_bit && notify; endproperty
    a_set: assert property (p_set) else $error("clamp flags apart");
    property p_hold; vout_minmax_warn && !clr |=> vout_minmax_warn; endproperty
    a_hold: assert property (p_hold) else $error("warning lost");
    property p_clr; clr && !req.wr |=> !vout_minmax_warn && !vout_word_bit; endproperty
    a_clr: assert property (p_clr) else $error("flags kept");
    property p_on; $rose(conv_enable) |-> $past(can_on); endproperty
    a_on: assert property (p_on) else $error("early turn on");
    property p_off; conv_enable && drop |=> !conv_enable; endproperty
    a_off: assert property (p_off) else $error("late turn off");
    c_clamp: cover property ($rose(vout_minmax_warn));
    c_read: cover property (rvalid);
    c_run: cover property ($rose(conv_enable));
endmodule

/* sim/vvl_host.sv */
`timescale 1ns/1ps
module vvl_host
    import vvl_pkg::*;
(
    input  wire logic        clk, // Clock
    output vvl_req_t         req, // Command
    input  wire logic [15:0] rdata, // Read word
    input  wire logic        rvalid // Read pulse
);
    initial req = '0;
    task automatic xfer(input logic [2:0] k, logic [7:0] c, logic [15:0] d, output logic [15:0] q);
        @(posedge clk);
        #1 req = {k, c, d};
        @(posedge clk);
        // Idle bus shows inverted values so a stale word never passes
        #1 req = {3'b000, ~c, ~d};
        q = rvalid ? rdata : 16'hXXXX;
    endtask
endmodule

/* sim/vvl_limits_tb.sv */
`timescale 1ns/1ps
module vvl_limits_tb;
    logic              clk = 1'b0, reset = 1'b1, power_up_ok = 1'b0, rvalid, run;
    logic       [11:0] vin_code = 12'h000;
    logic       [15:0] rdata, q;
    logic       [23:0] fb_ref;
    vvl_pkg::vvl_req_t req;
    wire         [3:0] flg;
    int                n_errors = 0, total_checks = 0;
    logic       [23:0] rst_t [9] = '{24'h200040,24'h210384,24'h240BB8,24'h250000,24'h260000,
        24'h29014F,24'h2B00FA,24'h350010,24'h36000B};
    logic       [43:0] wr_t [15] = '{44'h20FF1F005F0,44'h25F12301230,44'h240FFF0BB80,
        44'h2B000100FA0,44'h3500FF003C0,44'h35000100100,44'h360000000F0,44'h22123400000,
        44'h2901F401F40,44'h24080008000,44'h21FC000800F,44'h21001000FAF,44'h21050005000,
        44'h35002000200,44'h36001800180};
    logic       [15:0] cv_t [7] = '{16'h01F2,16'h0200,16'h0203,16'h0193,16'h0182,16'h0303,
        16'h0300};
    vvl_limits uut (.clk(clk), .reset(reset), .req(req), .vin_code(vin_code), .rvalid(rvalid),
        .power_up_ok(power_up_ok), .rdata(rdata), .fb_ref(fb_ref), .conv_enable(run),
        .other_fault_summary_bit(flg[3]), .vout_word_bit(flg[2]), .vout_minmax_warn(flg[1]),
        .notify(flg[0]));
    vvl_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        foreach (rst_t[i]) begin
            host.xfer(3'b010, rst_t[i][23:16], 16'h0000, q);
            chk(24'(q), 24'(rst_t[i][15:0]));
        end
        $display("reset test done");
        foreach (wr_t[i]) begin
            host.xfer(3'b100, wr_t[i][43:36], wr_t[i][35:20], q);
            chk(24'(flg), 24'(wr_t[i][3:0]));
            host.xfer(3'b010, wr_t[i][43:36], 16'h0000, q);
            chk(24'(q), 24'(wr_t[i][19:4]));
            host.xfer(3'b001, 8'h03, 16'h0000, q);
        end
        chk(fb_ref, 24'h500 * 24'h1F4);
        $display("write test done");
        foreach (cv_t[i]) begin
            {vin_code, power_up_ok} = {cv_t[i][15:4], cv_t[i][1]};
            @(posedge clk);
            #1 chk(24'(run), 24'(cv_t[i][0]));
        end
        $display("converter test done");
        final_report();
    end
endmodule
bind vvl_limits vvl_limits_monitor mon (.clk(clk), .reset(reset), .req(req), .rvalid(rvalid),
    .vin_code(vin_code), .power_up_ok(power_up_ok), .conv_enable(conv_enable), .notify(notify),
    .other_fault_summary_bit(other_fault_summary_bit), .vout_word_bit(vout_word_bit),
    .vout_minmax_warn(vout_minmax_warn));
